//--- src/bcm_top.sv
// bcm_top: breakpoint compare masking with its apb register file.
// assumes core bus signals synchronous to core_clk, one cycle each.
//
// Overview of operation
// - first mask: low bit clear full; 0:1 256 byte; 1:1 16K.
// - paged full compare: 6 ext to page, 14 bits to address.
// - unpaged full compare: high and low against address 15:0.
// - first mask 1:0 acts as full compare.
// - first mask 1:1 hits only on paged access with ext match.
// - second comparator in dual mode uses same mask encoding.
// - second comparator paged full compare spans twenty bits.
// - second mask 1:0 acts as full compare in dual mode.
// - second mask 1:1 in dual mode hits only on paged access with ext match.
// - full mode: second mask selects which data bytes compare.
// - full mode never uses second comparator extended byte.
// - bit 3 enables direction qualify for comparator A.
// - bit 2 picks write 0 or read 1, only when enabled.
// - bit 1 enables direction qualify for comparator B.
// - bit 0 picks write 0 or read 1, only when enabled.
// - full mode ignores both comparator B direction bits.
// - trace debug mode forces first mask to zero.
// - full: A address, B data; dual: both addresses.
`timescale 1ns/10ps
module bcm_top
  import bcm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire bcm_pkg::bcm_apb_req_s apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bcm_pkg::bcm_core_bus_s core,
  output logic match_a,
  output logic match_b,
  output logic break_req
);
  import bcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic setup;
  logic wr_stb;
  logic [7:0] mask_dir_reg;
  logic [7:0] cmp_reg [BCM_NCMP];
  logic [2:0] mode_reg;
  logic [1:0] hit_reg;
  logic [1:0] hit_next;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic match_a_reg;
  logic match_b_reg;
  logic break_reg;
  logic hit_a;
  logic hit_b;
  logic bkp_on;
  logic trace_on;
  logic full_on;
  bcm_cmp_cfg_s cfg_a;
  bcm_cmp_cfg_s cfg_b;

  bcm_apb_slv u_apb (
    .core_clk(core_clk),
    .srst(srst),
    .apb(apb),
    .pready(pready),
    .pslverr(pslverr),
    .setup(setup),
    .wr_stb(wr_stb)
  );

  // mask and direction control byte
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask_dir_reg <= BCM_RST_BYTE;
    end else if (wr_stb && apb.paddr == BCM_OFS_MASK_DIR) begin
      mask_dir_reg <= apb.pwdata[7:0];
    end
  end

  // mode byte: breakpoint only, full, trace debug
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= BCM_RST_MODE;
    end else if (wr_stb && apb.paddr == BCM_OFS_MODE) begin
      mode_reg <= apb.pwdata[2:0];
    end
  end

  // six compare bytes at consecutive words
  genvar gi;
  generate
    for (gi = 0; gi < BCM_NCMP; gi++) begin : g_cmp
      always_ff @(posedge core_clk) begin
        if (srst) begin
          cmp_reg[gi] <= BCM_RST_BYTE;
        end else if (wr_stb && apb.paddr ==
                     8'(BCM_OFS_CMP0 + BCM_WORD * 8'(gi))) begin
          cmp_reg[gi] <= apb.pwdata[7:0];
        end
      end
    end
  endgenerate

  // sticky hits: write one clears, a new hit in that cycle wins
  always_comb begin
    hit_next = hit_reg;
    if (wr_stb && apb.paddr == BCM_OFS_STATUS) begin
      hit_next = hit_reg & ~apb.pwdata[1:0];
    end
    hit_next[BCM_ST_HIT_A] = hit_next[BCM_ST_HIT_A] | match_a_reg;
    hit_next[BCM_ST_HIT_B] = hit_next[BCM_ST_HIT_B] | match_b_reg;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hit_reg <= 2'h0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  // read mux; upper bits and holes read zero
  always_comb begin
    rd_next = BCM_RST_WORD;
    if (apb.paddr == BCM_OFS_MASK_DIR) begin
      rd_next[7:0] = mask_dir_reg;
    end else if (apb.paddr == BCM_OFS_MODE) begin
      rd_next[2:0] = mode_reg;
    end else if (apb.paddr == BCM_OFS_STATUS) begin
      rd_next[1:0] = hit_reg;
    end else begin
      for (int i = 0; i < BCM_NCMP; i++) begin
        if (apb.paddr == 8'(BCM_OFS_CMP0 + BCM_WORD * 8'(i))) begin
          rd_next[7:0] = cmp_reg[i];
        end
      end
    end
  end

  // read data captured in setup, held through the access phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_reg <= BCM_RST_WORD;
    end else if (setup && !apb.pwrite) begin
      prdata_reg <= rd_next;
    end
  end

  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // mode and comparator configuration

  // breakpoint only mode overrides trace debug mode
  assign bkp_on = mode_reg[BCM_MODE_BKP];
  assign trace_on = mode_reg[BCM_MODE_TRACE] & ~bkp_on;
  assign full_on = mode_reg[BCM_MODE_FULL];

  // comparator A: address always
  always_comb begin
    cfg_a.mask = {mask_dir_reg[BCM_A_MSB], mask_dir_reg[BCM_A_LSB]};
    if (trace_on) begin
      cfg_a.mask = 2'b00;
    end
    cfg_a.dir_en = mask_dir_reg[BCM_A_DEN];
    cfg_a.dir_val = mask_dir_reg[BCM_A_DVAL];
    cfg_a.ext = cmp_reg[BCM_AX];
    cfg_a.high = cmp_reg[BCM_AH];
    cfg_a.low = cmp_reg[BCM_AL];
  end

  // comparator B: address in dual, data in full
  always_comb begin
    cfg_b.mask = {mask_dir_reg[BCM_B_MSB], mask_dir_reg[BCM_B_LSB]};
    cfg_b.dir_en = mask_dir_reg[BCM_B_DEN] & ~full_on;
    cfg_b.dir_val = mask_dir_reg[BCM_B_DVAL];
    cfg_b.ext = cmp_reg[BCM_BX];
    cfg_b.high = cmp_reg[BCM_BH];
    cfg_b.low = cmp_reg[BCM_BL];
  end

  bcm_cmp_unit u_cmp_a (
    .cfg(cfg_a),
    .bus(core),
    .data_mode(1'b0),
    .hit(hit_a)
  );

  bcm_cmp_unit u_cmp_b (
    .cfg(cfg_b),
    .bus(core),
    .data_mode(full_on),
    .hit(hit_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // match outputs and break request

  // one cycle latency from bus cycle to match flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      match_a_reg <= 1'b0;
      match_b_reg <= 1'b0;
    end else begin
      match_a_reg <= core.valid & hit_a;
      match_b_reg <= core.valid & hit_b;
    end
  end

  // full mode needs address and data together; dual takes either
  always_ff @(posedge core_clk) begin
    if (srst) begin
      break_reg <= 1'b0;
    end else begin
      break_reg <= core.valid & (bkp_on | trace_on) &
                   (full_on ? (hit_a & hit_b) : (hit_a | hit_b));
    end
  end

  assign match_a = match_a_reg;
  assign match_b = match_b_reg;
  assign break_req = break_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic a_dir_free;
  logic a_page20_eq;
  logic a_flat_eq;
  assign a_dir_free = ~cfg_a.dir_en;
  assign a_page20_eq = core.page_acc &&
    core.page == cfg_a.ext[BCM_XB_W-1:0] &&
    core.addr[BCM_LO_W+BCM_XB_W-1:BCM_LO_W] ==
      cfg_a.high[BCM_XB_W-1:0] &&
    core.addr[BCM_LO_W-1:0] == cfg_a.low;
  assign a_flat_eq = !core.page_acc &&
    core.addr == {cfg_a.high, cfg_a.low};

  sequence s_ctrl_write;
    wr_stb && apb.paddr == BCM_OFS_MASK_DIR;
  endsequence

  sequence s_setup_then_access;
    setup ##1 (apb.psel && apb.penable);
  endsequence

  chk_a_paged_full: assert property (
    core.valid && !cfg_a.mask[0] && a_dir_free && a_page20_eq
    |=> match_a_reg)
    else $error("paged full compare on A missed");

  chk_a_flat_full: assert property (
    core.valid && !cfg_a.mask[0] && a_dir_free && a_flat_eq &&
    core.page != cfg_a.ext[BCM_XB_W-1:0]
    |=> match_a_reg)
    else $error("flat compare on A used the extended byte");

  chk_a_page_only: assert property (
    cfg_a.mask == 2'b11 && !core.page_acc |=> !match_a_reg)
    else $error("page range on A hit without paged access");

  chk_a_range_hit: assert property (
    core.valid && cfg_a.mask == 2'b01 && a_dir_free &&
    core.page_acc && core.page == cfg_a.ext[BCM_XB_W-1:0] &&
    core.addr[BCM_LO_W+BCM_XB_W-1:BCM_LO_W] ==
      cfg_a.high[BCM_XB_W-1:0]
    |=> match_a_reg)
    else $error("256 byte range on A missed");

  chk_a_dir_block: assert property (
    cfg_a.dir_en && core.rnw != cfg_a.dir_val |=> !match_a_reg)
    else $error("A matched the wrong direction");

  chk_b_no_data: assert property (
    core.valid && full_on && cfg_b.mask == 2'b11 |=> match_b_reg)
    else $error("no data compare on B did not match");

  chk_b_full_dir: assert property (
    core.valid && full_on && cfg_b.mask == 2'b00 &&
    core.data == {cfg_b.high, cfg_b.low}
    |=> match_b_reg)
    else $error("data match on B qualified by direction");

  chk_b_dir_block: assert property (
    !full_on && mask_dir_reg[BCM_B_DEN] &&
    core.rnw != mask_dir_reg[BCM_B_DVAL] |=> !match_b_reg)
    else $error("B matched the wrong direction");

  // a forced mask must still give the full flat compare, whatever is stored
  chk_trace_mask_zero: assert property (
    trace_on && core.valid && a_dir_free && a_flat_eq |=> match_a_reg)
    else $error("first mask not forced in trace debug mode");

  chk_ctrl_write: assert property (
    s_ctrl_write |=> mask_dir_reg == $past(apb.pwdata[7:0]))
    else $error("control write not stored");

  chk_apb_ready: assert property (
    s_setup_then_access |-> pready)
    else $error("ready late in access phase");

endmodule

//--- src/bcm_pkg.sv
// bcm_pkg: constants, carriers and decode helpers for the breakpoint
// compare masking block; shared by the top, the apb slave and comparators.
package bcm_pkg;

  // register byte offsets on the apb port
  localparam logic [7:0] BCM_OFS_MASK_DIR = 8'h00;
  localparam logic [7:0] BCM_OFS_CMP0 = 8'h04;
  localparam logic [7:0] BCM_OFS_MODE = 8'h1c;
  localparam logic [7:0] BCM_OFS_STATUS = 8'h20;
  localparam logic [7:0] BCM_WORD = 8'h04;
  localparam int BCM_NCMP = 6;

  // compare byte order in the compare array
  localparam int BCM_AX = 0;
  localparam int BCM_AH = 1;
  localparam int BCM_AL = 2;
  localparam int BCM_BX = 3;
  localparam int BCM_BH = 4;
  localparam int BCM_BL = 5;

  // mask and direction control field positions
  localparam int BCM_A_MSB = 7;
  localparam int BCM_A_LSB = 6;
  localparam int BCM_B_MSB = 5;
  localparam int BCM_B_LSB = 4;
  localparam int BCM_A_DEN = 3;
  localparam int BCM_A_DVAL = 2;
  localparam int BCM_B_DEN = 1;
  localparam int BCM_B_DVAL = 0;

  // mode and status field positions
  localparam int BCM_MODE_BKP = 0;
  localparam int BCM_MODE_FULL = 1;
  localparam int BCM_MODE_TRACE = 2;
  localparam int BCM_ST_HIT_A = 0;
  localparam int BCM_ST_HIT_B = 1;

  // widths and reset values
  localparam int BCM_LO_W = 8;
  localparam int BCM_XB_W = 6;
  localparam logic [7:0] BCM_RST_BYTE = 8'h00;
  localparam logic [2:0] BCM_RST_MODE = 3'h0;
  localparam logic [31:0] BCM_RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } bcm_apb_req_s;

  typedef struct packed {
    logic valid;
    logic rnw;
    logic page_acc;
    logic [5:0] page;
    logic [15:0] addr;
    logic [15:0] data;
  } bcm_core_bus_s;

  typedef struct packed {
    logic [1:0] mask;
    logic dir_en;
    logic dir_val;
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } bcm_cmp_cfg_s;

  typedef struct packed {
    logic ext;
    logic high;
    logic low;
  } bcm_sel_s;

  // which compare bytes take part, from the two mask bits
  function automatic bcm_sel_s bcm_byte_sel(input logic [1:0] mask,
                                            input logic data_mode);
    bcm_sel_s s;
    if (data_mode) begin
      s.ext = 1'b0;
      s.high = ~mask[1];
      s.low = ~mask[0];
    end else begin
      s.ext = 1'b1;
      s.high = ~(mask[0] & mask[1]);
      s.low = ~mask[0];
    end
    return s;
  endfunction

  function automatic logic bcm_is_mapped(input logic [7:0] a);
    return (a == BCM_OFS_MASK_DIR) || (a == BCM_OFS_MODE) ||
           (a == BCM_OFS_STATUS) ||
           ((a >= BCM_OFS_CMP0) && (a < BCM_OFS_MODE) &&
            (a[1:0] == 2'b00));
  endfunction

endpackage

//--- src/bcm_cmp_unit.sv
// bcm_cmp_unit: one breakpoint comparator, address or data match.
// assumes a registered config and a core bus stable for the cycle.
`timescale 1ns/10ps
module bcm_cmp_unit
  import bcm_pkg::*;
(
  input wire bcm_pkg::bcm_cmp_cfg_s cfg,
  input wire bcm_pkg::bcm_core_bus_s bus,
  input wire logic data_mode,
  output logic hit
);
  import bcm_pkg::*;

  bcm_sel_s sel;
  logic ext_eq;
  logic hi_eq;
  logic lo_eq;
  logic dir_ok;

  assign sel = bcm_byte_sel(cfg.mask, data_mode);
  assign ext_eq = (bus.page == cfg.ext[BCM_XB_W-1:0]);
  assign dir_ok = ~cfg.dir_en | (bus.rnw == cfg.dir_val);

  // byte equality, paged or flat address, or data bytes
  always_comb begin
    lo_eq = data_mode ? (bus.data[BCM_LO_W-1:0] == cfg.low)
                      : (bus.addr[BCM_LO_W-1:0] == cfg.low);
    if (data_mode) begin
      hi_eq = (bus.data[2*BCM_LO_W-1:BCM_LO_W] == cfg.high);
    end else if (bus.page_acc) begin
      hi_eq = (bus.addr[BCM_LO_W+BCM_XB_W-1:BCM_LO_W] ==
               cfg.high[BCM_XB_W-1:0]);
    end else begin
      hi_eq = (bus.addr[2*BCM_LO_W-1:BCM_LO_W] == cfg.high);
    end
  end

  // combine per mode
  always_comb begin
    if (data_mode) begin
      hit = (~sel.high | hi_eq) & (~sel.low | lo_eq);
    end else if (bus.page_acc) begin
      hit = (~sel.ext | ext_eq) & (~sel.high | hi_eq) &
            (~sel.low | lo_eq) & dir_ok;
    end else begin
      hit = sel.high & hi_eq & (~sel.low | lo_eq) & dir_ok;
    end
  end

endmodule

//--- src/bcm_apb_slv.sv
// bcm_apb_slv: apb handshake and decode for the breakpoint block.
// assumes a standard apb master; answers with no wait states.
`timescale 1ns/10ps
module bcm_apb_slv
  import bcm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire bcm_pkg::bcm_apb_req_s apb,
  output logic pready,
  output logic pslverr,
  output logic setup,
  output logic wr_stb
);
  import bcm_pkg::*;

  logic pready_reg;
  logic pslverr_reg;

  assign setup = apb.psel & ~apb.penable;

  // ready one cycle after setup, so read data can come from a flop
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~bcm_is_mapped(apb.paddr);
    end
  end

  // refused writes to holes change nothing
  assign wr_stb = apb.psel & apb.penable & apb.pwrite & pready_reg &
                  ~pslverr_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

//--- verif/bcm_core_model.sv
// bcm_core_model: behavioural processor core bus for the bench.
// assumes the bench pulses go for one cycle per requested bus cycle.
`timescale 1ns/10ps
module bcm_core_model
  import bcm_pkg::*;
(
  input wire logic core_clk,
  input wire logic go,
  input wire bcm_pkg::bcm_core_bus_s req,
  output bcm_pkg::bcm_core_bus_s core
);
  import bcm_pkg::*;

  // one core cycle per request; idle lines flip every cycle so a stale
  // value can never pass for a real cycle; one process drives the bus
  initial begin
    core = '0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        core <= req;
      end else begin
        core <= {1'b0, ~core[39:0]};
      end
    end
  end
endmodule

//--- verif/breakpoint_compare_masking_bench.sv
// breakpoint_compare_masking_bench: random and corner checks of bcm_top.
// assumes bcm_core_model as the core bus and an apb master made here.
`timescale 1ns/10ps
module breakpoint_compare_masking_bench;
  import bcm_pkg::*;
  logic core_clk;
  logic srst;
  bcm_apb_req_s apb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bcm_core_bus_s core;
  bcm_core_bus_s req;
  logic go;
  logic match_a;
  logic match_b;
  logic break_req;
  int n_mismatch;
  int tests_run;
  integer seed;
  logic [7:0] cmp [BCM_NCMP];
  logic [7:0] ctl;
  logic [2:0] mode;
  logic [31:0] rd;
  logic err;
  logic [1:0] st_exp;
  // every mode code; bkp wins over trace, 0 and 2 never break
  // trace mode offered to software
  logic [2:0] modes [8] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0, 3'h2, 3'h6};

  bcm_top uut (.core_clk(core_clk), .srst(srst), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
    .match_a(match_a), .match_b(match_b), .break_req(break_req));
  bcm_core_model partner (.core_clk(core_clk), .go(go), .req(req),
    .core(core));

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer; waits a cycle first so psel never toggles in a step
  task automatic apb_xfer(input logic [7:0] a, input logic w,
                          input logic [31:0] d);
    int n;
    @(posedge core_clk);
    apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge core_clk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1, "pready never came");
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  // address compare under a mask; 1:0 folds onto full compare
  function automatic logic addr_hit(input logic [1:0] m,
    input logic [7:0] x, input logic [7:0] h, input logic [7:0] l,
    input bcm_core_bus_s b);
    logic [1:0] k;
    k = (m == 2'b10) ? 2'b00 : m;
    if (b.page_acc)
      return x[5:0] == b.page && (k == 2'b11 || h[5:0] == b.addr[13:8])
             && (k[0] || l == b.addr[7:0]);
    return k != 2'b11 && h == b.addr[15:8] && (k[0] || l == b.addr[7:0]);
  endfunction

  // returns break, hit b, hit a
  function automatic logic [2:0] expect_hits(input bcm_core_bus_s b);
    logic full;
    logic ha;
    logic hb;
    full = mode[1];
    ha = b.valid && (!ctl[3] || b.rnw == ctl[2]) &&
         addr_hit((mode[2] && !mode[0]) ? 2'b00 : ctl[7:6], cmp[BCM_AX],
                  cmp[BCM_AH], cmp[BCM_AL], b);
    if (full)
      hb = b.valid && (ctl[5] || b.data[15:8] == cmp[BCM_BH]) &&
           (ctl[4] || b.data[7:0] == cmp[BCM_BL]);
    else
      hb = b.valid && (!ctl[1] || b.rnw == ctl[0]) &&
           addr_hit(ctl[5:4], cmp[BCM_BX], cmp[BCM_BH], cmp[BCM_BL], b);
    return {(mode[0] | mode[2]) && (full ? ha & hb : ha | hb), hb, ha};
  endfunction

  // a cycle aimed at one comparator, then perhaps one bit spoiled
  function automatic bcm_core_bus_s make_bus();
    bcm_core_bus_s b;
    int base;
    int r;
    base = (mode[1] || $random(seed) & 1) ? BCM_AX : BCM_BX;
    b.valid = 1'b1;
    b.rnw = 1'($random(seed));
    b.page_acc = 1'($random(seed));
    b.page = cmp[base][5:0];
    b.addr = b.page_acc ?
      {2'($random(seed)), cmp[base+1][5:0], cmp[base+2]} :
      {cmp[base+1], cmp[base+2]};
    b.data = {cmp[BCM_BH], cmp[BCM_BL]};
    r = ($random(seed) & 32'h7f) % 80;
    if (r < 16) b.addr[r] = ~b.addr[r];
    else if (r < 32) b.data[r-16] = ~b.data[r-16];
    else if (r < 38) b.page[r-32] = ~b.page[r-32];
    else if (r == 38) b.rnw = ~b.rnw;
    else if (r == 39) b.valid = 1'b0;
    return b;
  endfunction

  task automatic core_op(input bcm_core_bus_s b);
    logic [2:0] e;
    @(posedge core_clk);
    req <= b;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    #1;
    e = expect_hits(b);
    st_exp = st_exp | e[1:0];
    check(32'(match_a), 32'(e[0]), "match_a");
    check(32'(match_b), 32'(e[1]), "b hit");
    check(32'(break_req), 32'(e[2]), "break_req");
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // watchdog well beyond the expected run of some 20 us
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    seed = 32'h3ec954d7;
    srst = 1'b1;
    apb = '0;
    go = 1'b0;
    req = '0;
    st_exp = 2'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb_xfer(8'(i * 4), 1'b0, 32'h0);
      check(rd, BCM_RST_WORD, "reset value");
      check(32'(err), 32'h0, "mapped error");
    end
    $display("test reset values done");
    // unmapped and misaligned places answer with an error, read zero
    apb_xfer(8'h24, 1'b1, 32'hff);
    apb_xfer(8'h24, 1'b0, 32'h0);
    check(32'(err), 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped read");
    apb_xfer(8'h06, 1'b0, 32'h0);
    check(32'(err), 32'h1, "misaligned error");
    $display("test unmapped done");
    // first 16 configs walk every mask pair; the rest are random
    for (int t = 0; t < 80; t++) begin
      // no tagged cycles here, so direction qualify is fair game
      ctl = 8'($random(seed));
      if (t < 16) ctl[7:4] = 4'(t);
      mode = modes[t % 8];
      for (int i = 0; i < BCM_NCMP; i++) begin
        cmp[i] = 8'($random(seed));
        apb_xfer(BCM_OFS_CMP0 + BCM_WORD * 8'(i), 1'b1, {24'h0, cmp[i]});
      end
      apb_xfer(BCM_OFS_MASK_DIR, 1'b1, {24'h0, ctl});
      apb_xfer(BCM_OFS_MODE, 1'b1, {29'h0, mode});
      if (mode[0]) begin
        apb_xfer(BCM_OFS_MASK_DIR, 1'b0, 32'h0);
        check(rd, {24'h0, ctl}, "control readback");
      end
      repeat (4) core_op(make_bus());
      // sticky hits gather every match, then write one clears them
      apb_xfer(BCM_OFS_STATUS, 1'b0, 32'h0);
      check(rd, {30'h0, st_exp}, "sticky hits");
      apb_xfer(BCM_OFS_STATUS, 1'b1, 32'h3);
      apb_xfer(BCM_OFS_STATUS, 1'b0, 32'h0);
      check(rd, 32'h0, "hits cleared");
      st_exp = 2'h0;
    end
    $display("test random compares done");
    conclude();
  end
endmodule
